//--- shared/dbg_cmd_pkg.sv
// package: constants and carriers for the debug command executor
package dbg_cmd_pkg;
  localparam logic [7:0] CMD_CRC      = 8'h0E;
  localparam logic [7:0] CMD_STEP     = 8'h10;
  localparam logic [7:0] CMD_STUFF    = 8'h11;
  localparam logic [7:0] CMD_EXEC     = 8'h12;
  localparam logic [7:0] CTL_RST_STOP = 8'h81;
  localparam logic [7:0] CTL_RST_GO   = 8'h41;
  localparam logic [7:0] CTL_RUN      = 8'h40;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam int         CTL_DBG_BIT  = 7;
  localparam int         CTL_BRK_BIT  = 6;
  localparam int         CTL_RST_BIT  = 0;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam int          MEM_BYTES   = 8192;
  localparam int          ADDR_W      = 16;

  // byte from the host side receiver
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_t;

  // instruction handed to the core
  typedef struct packed {
    logic        valid;
    logic        useMem;   // fetch remaining bytes from program memory
    logic [2:0]  len;
    logic [39:0] bytes;
  } instr_t;
endpackage

//--- logic/debug_command_executor.sv
// debug command executor: step, stuff, execute, crc, control register
`timescale 1ns/1ps
module debug_command_executor
  import dbg_cmd_pkg::*;
#(
  parameter int MEM_SIZE = MEM_BYTES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire dbg_cmd_pkg::byte_t   rxByte,
  input  wire logic                 txReady,
  output dbg_cmd_pkg::byte_t        txByte,
  input  wire logic                 ctlWrite,
  input  wire logic [7:0]           ctlData,
  output logic [7:0]                ctlValue,
  input  wire logic                 codeReadLockPin,
  output dbg_cmd_pkg::instr_t       instrOut,
  input  wire logic                 instrDone,
  output logic                      cpuHalt,
  output logic                      deviceReset,
  output logic [dbg_cmd_pkg::ADDR_W-1:0] memAddr,
  output logic                      memRead,
  input  wire logic [7:0]           memData
);
  import dbg_cmd_pkg::*;

  typedef enum {
    S_IDLE, S_OPC, S_BODY, S_DISCARD, S_RUN, S_CRC, S_TX_HI, S_TX_LO
  } state_t;

  // lock pin is asynchronous: two flops before use
  logic lockMeta_q, lockSync_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lockMeta_q <= 1'b0;
      lockSync_q <= 1'b0;
    end else begin
      lockMeta_q <= codeReadLockPin;
      lockSync_q <= lockMeta_q;
    end
  end

  state_t          state_q, state_d;
  logic [7:0]      ctl_q, ctl_d;
  logic [7:0]      cmd_q, cmd_d;
  logic [2:0]      need_q, need_d;
  logic [2:0]      got_q, got_d;
  logic [39:0]     buf_q, buf_d;
  instr_t          instr_q, instr_d;
  logic [15:0]     crc_q, crc_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic            rd_q, rd_d;
  byte_t           tx_q, tx_d;
  logic            rst_q, rst_d;

  wire inDebug  = ctl_q[CTL_DBG_BIT];
  wire allowed  = inDebug && !lockSync_q;
  wire rxV      = rxByte.valid;
  wire [7:0] rxD = rxByte.data;

  // instruction length from opcode low nibble, with 0x1F and 0x00 decoded whole; plain table kept small
  function automatic logic [2:0] op_len(input logic [7:0] op);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = op[3:0];
    hi = op[7:4];
    if (op == 8'h1F)                      op_len = 3'd4;   // prefixed page
    else if (lo == 4'hF || lo == 4'hE)    op_len = 3'd1;
    else if (lo == 4'hC || lo == 4'hB || lo == 4'hD)
      op_len = (lo == 4'hD) ? 3'd3 : 3'd2;
    else if (lo == 4'h8 || lo == 4'h9)    op_len = 3'd4;
    else if (lo == 4'h2 || lo == 4'h3)    op_len = 3'd2;
    else if (hi == 4'h0 && lo == 4'h0)    op_len = 3'd1;
    else                                  op_len = 3'd3;
  endfunction

  // one byte crc-ccitt step
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    crc_step = r;
  endfunction

  wire lastAddr = (addr_q == ADDR_W'(MEM_SIZE - 1));
  wire [39:0] bufNext = buf_q | (40'(rxD) << {got_q, 3'b000});

  always_comb begin
    state_d = state_q;
    ctl_d   = ctl_q;
    cmd_d   = cmd_q;
    need_d  = need_q;
    got_d   = got_q;
    buf_d   = buf_q;
    instr_d = instr_q;
    crc_d   = crc_q;
    addr_d  = addr_q;
    rd_d    = 1'b0;
    tx_d    = tx_q;
    rst_d   = 1'b0;
    instr_d.valid = 1'b0;
    if (tx_q.valid && txReady) tx_d.valid = 1'b0;

    // control register write; reset values pulse the device reset
    if (ctlWrite) begin
      ctl_d = ctlData;
      if (ctlData == CTL_RST_STOP) rst_d = 1'b1;
      if (ctlData == CTL_RST_GO)   rst_d = 1'b1;
      if (ctlData == CTL_RUN && !inDebug)
        ctl_d = ctl_q;             // run only from halted state
      ctl_d[CTL_RST_BIT] = 1'b0;  // reset bit self clears
    end

    unique case (state_q)
      S_IDLE: begin
        if (rxV) begin
          cmd_d = rxD;
          got_d = '0;
          buf_d = '0;
          if (rxD == CMD_STEP && allowed) begin
            instr_d.valid  = 1'b1;
            instr_d.useMem = 1'b1;
            instr_d.len    = 3'd0;
            instr_d.bytes  = '0;
            state_d        = S_RUN;
          end else if (rxD == CMD_STUFF && allowed) begin
            state_d = S_OPC;
          end else if (rxD == CMD_EXEC) begin
            state_d = allowed ? S_OPC : S_DISCARD;
          end else if (rxD == CMD_CRC && !lockSync_q) begin
            crc_d   = CRC_INIT;
            addr_d  = '0;
            rd_d    = 1'b1;
            state_d = S_CRC;
          end
        end
      end
      S_OPC: begin
        if (rxV) begin
          buf_d = {32'h0, rxD};
          got_d = 3'd1;
          if (cmd_q == CMD_STUFF) begin
            // core fetches operands from memory, opcode replaced
            instr_d.valid  = 1'b1;
            instr_d.useMem = 1'b1;
            instr_d.len    = 3'd1;
            instr_d.bytes  = {32'h0, rxD};
            state_d        = S_RUN;
          end else begin
            need_d = op_len(rxD);
            if (op_len(rxD) == 3'd1) begin
              instr_d.valid  = 1'b1;
              instr_d.useMem = 1'b0;
              instr_d.len    = 3'd1;
              instr_d.bytes  = {32'h0, rxD};
              state_d        = S_RUN;
            end else begin
              state_d = S_BODY;
            end
          end
        end
      end
      S_BODY: begin
        if (rxV) begin
          buf_d = bufNext;
          got_d = got_q + 3'd1;
          if (got_q + 3'd1 == need_q) begin
            instr_d.valid  = 1'b1;
            instr_d.useMem = 1'b0;
            instr_d.len    = need_q;
            instr_d.bytes  = bufNext;
            state_d        = S_RUN;
          end
        end
      end
      S_DISCARD: begin
        if (rxV) state_d = S_IDLE;
      end
      S_RUN: begin
        // back to halted once the core finishes the one instruction
        if (instrDone) state_d = S_IDLE;
      end
      S_CRC: begin
        // memData is the byte at the current memAddr, addressed in this same cycle
        crc_d = crc_step(crc_q, memData);
        if (lastAddr) begin
          state_d = S_TX_HI;
        end else begin
          addr_d = addr_q + ADDR_W'(1);
          rd_d   = 1'b1;
        end
      end
      S_TX_HI: begin
        if (!tx_q.valid || txReady) begin
          tx_d    = '{valid: 1'b1, data: crc_q[15:8]};
          state_d = S_TX_LO;
        end
      end
      S_TX_LO: begin
        if (txReady) begin
          tx_d    = '{valid: 1'b1, data: crc_q[7:0]};
          state_d = S_IDLE;
        end
      end
    endcase
    // a device reset aborts any command in flight
    if (rst_q) begin
      state_d = S_IDLE;
      instr_d.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      ctl_q   <= CTL_RESET;
      cmd_q   <= 8'h00;
      need_q  <= 3'd0;
      got_q   <= 3'd0;
      buf_q   <= '0;
      instr_q <= '0;
      crc_q   <= CRC_INIT;
      addr_q  <= '0;
      rd_q    <= 1'b0;
      tx_q    <= '0;
      rst_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      ctl_q   <= ctl_d;
      cmd_q   <= cmd_d;
      need_q  <= need_d;
      got_q   <= got_d;
      buf_q   <= buf_d;
      instr_q <= instr_d;
      crc_q   <= crc_d;
      addr_q  <= addr_d;
      rd_q    <= rd_d;
      tx_q    <= tx_d;
      rst_q   <= rst_d;
    end
  end

  // halt follows debug bit; core stays halted even while running one step
  logic halt_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) halt_q <= 1'b0;
    else       halt_q <= ctl_d[CTL_DBG_BIT];
  end

  assign txByte      = tx_q;
  assign ctlValue    = ctl_q;
  assign instrOut    = instr_q;
  assign cpuHalt     = halt_q;
  assign deviceReset = rst_q;
  assign memAddr     = addr_q;
  assign memRead     = rd_q;
endmodule

//--- sim/debug_command_executor_props.sv
// checker: port-level properties of the debug command executor
`timescale 1ns/1ps
module debug_command_executor_props
  import dbg_cmd_pkg::*;
#(parameter int MEM_SIZE = MEM_BYTES) (
  input wire logic                clk_sys,
  input wire logic                nrst,
  input wire dbg_cmd_pkg::byte_t  rxByte,
  input wire logic                txReady,
  input wire dbg_cmd_pkg::byte_t  txByte,
  input wire logic                ctlWrite,
  input wire logic [7:0]          ctlData,
  input wire logic                codeReadLockPin,
  input wire dbg_cmd_pkg::instr_t instrOut,
  input wire logic                cpuHalt,
  input wire logic                deviceReset,
  input wire logic [ADDR_W-1:0]   memAddr,
  input wire logic                memRead
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_ctl(v);
    ctlWrite && ctlData == v;
  endsequence
  // lock pin must sit still long enough to pass its synchroniser
  sequence s_cmd(v, lk);
    (codeReadLockPin == lk && cpuHalt) [*3]
      ##0 rxByte.valid && rxByte.data == v;
  endsequence
  property p_stop; s_ctl(CTL_RST_STOP) |=> deviceReset && cpuHalt; endproperty
  a_stop: assert property (p_stop) else $error("stop write");
  property p_go; s_ctl(CTL_RST_GO) |=> deviceReset && !cpuHalt; endproperty
  a_go: assert property (p_go) else $error("go write");
  property p_run;
    s_ctl(CTL_RUN) ##0 cpuHalt |=> !cpuHalt && !deviceReset;
  endproperty
  a_run: assert property (p_run) else $error("run write");
  property p_step;
    s_cmd(CMD_STEP, 1'b0) |=> instrOut.valid && instrOut.len == 3'h0;
  endproperty
  a_step: assert property (p_step) else $error("step issue");
  property p_lock; s_cmd(CMD_STEP, 1'b1) |=> !instrOut.valid [*2]; endproperty
  a_lock: assert property (p_lock) else $error("locked step");
  property p_len;
    instrOut.valid && !instrOut.useMem |-> instrOut.len inside {[1:5]};
  endproperty
  a_len: assert property (p_len) else $error("exec length");
  property p_tx;
    txByte.valid && !txReady |=> txByte.valid && $stable(txByte.data);
  endproperty
  a_tx: assert property (p_tx) else $error("reply held");
  property p_addr; memRead |-> memAddr < MEM_SIZE; endproperty
  a_addr: assert property (p_addr) else $error("crc address");
endmodule

bind debug_command_executor debug_command_executor_props #(
  .MEM_SIZE(MEM_SIZE)
) u_props (.clk_sys, .nrst, .rxByte, .txReady, .txByte, .ctlWrite, .ctlData,
  .codeReadLockPin, .instrOut, .cpuHalt, .deviceReset, .memAddr, .memRead);

//--- sim/dbg_host_model.sv
// host model: sends command bytes, takes reply bytes at its own pace
`timescale 1ns/1ps
module dbg_host_model (
  input  wire logic               clk_sys,
  output dbg_cmd_pkg::byte_t      rxByte,
  output logic                    txReady,
  input  wire dbg_cmd_pkg::byte_t txByte
);
  import dbg_cmd_pkg::*;
  initial begin
    rxByte = '0;
    txReady = 1'b0;
  end
  // released data shows the inverse so a stale byte never looks valid
  task automatic send(input logic [7:0] b);
    @(negedge clk_sys);
    rxByte = {1'b1, b};
    @(negedge clk_sys);
    rxByte = {1'b0, ~b};
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic take(input int lag, output logic got, output logic [7:0] b);
    got = 1'b0;
    b = 8'h00;
    for (int i = 0; i < 200 && !txByte.valid; i++) @(negedge clk_sys);
    if (txByte.valid) begin
      repeat (lag) @(negedge clk_sys);
      got = 1'b1;
      b = txByte.data;
      txReady = 1'b1;
      @(negedge clk_sys);
      txReady = 1'b0;
    end
  endtask
endmodule

//--- sim/debug_command_executor_tb_top.sv
// testbench: commands, control writes and lock pin against expectations
`timescale 1ns/1ps
module debug_command_executor_tb_top;
  import dbg_cmd_pkg::*;
  localparam int MSZ = 16;
  logic              clk_sys = 1'b0;
  logic              nrst = 1'b0;
  byte_t             rxByte, txByte;
  instr_t            instrOut;
  logic              txReady, cpuHalt, deviceReset, memRead, r, g;
  logic              ctlWrite = 1'b0, instrDone = 1'b0, lockPin = 1'b0;
  logic [7:0]        ctlData = 8'h00, ctlValue, memData, hi, lo;
  logic [ADDR_W-1:0] memAddr;
  logic [15:0]       c;
  int                err_total = 0;
  int                n_checks = 0;
  int                nInstr = 0;
  int                nTaken = 0;
  instr_t            lastInstr = '0;
  always #4 clk_sys = ~clk_sys;
  function automatic logic [7:0] memByte(input logic [ADDR_W-1:0] a);
    return a[7:0] * 8'h1D + 8'h05;
  endfunction
  // the crc walk folds memData in the cycle memRead stands: read is
  // combinational on the registered address; unread shows the inverse
  assign memData = memRead ? memByte(memAddr) : ~memByte(memAddr);
  // issue pulses last one cycle and end while send is still idling
  always @(negedge clk_sys) begin
    if (instrOut.valid === 1'b1) begin
      nInstr    <= nInstr + 1;
      lastInstr <= instrOut;
    end
  end
  debug_command_executor #(.MEM_SIZE(MSZ)) u_debug_command_executor (
    .clk_sys, .nrst, .rxByte, .txReady, .txByte, .ctlWrite, .ctlData,
    .ctlValue, .codeReadLockPin(lockPin), .instrOut, .instrDone, .cpuHalt,
    .deviceReset, .memAddr, .memRead, .memData);
  dbg_host_model u_dbg_host_model (.clk_sys, .rxByte, .txReady, .txByte);
  task automatic chkv(string w, logic [43:0] e, logic [43:0] s);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic ctl(input logic [7:0] v);
    @(negedge clk_sys);
    ctlData = v;
    ctlWrite = 1'b1;
    @(negedge clk_sys);
    ctlWrite = 1'b0;
    r = deviceReset;
  endtask
  // core model: answers each issued instruction some cycles later
  task automatic expInstr(input logic en, input logic [43:0] e);
    logic seen;
    instr_t v;
    repeat (12) @(negedge clk_sys);
    seen = (nInstr != nTaken);
    v = lastInstr;
    chkv("issued", 44'(en), 44'(nInstr - nTaken));
    nTaken = nInstr;
    if (en) chkv("instr", e, {v.useMem, v.len,
      v.bytes & ~({40{1'b1}} << (8 * e[42:40]))});
    instrDone = seen;
    @(negedge clk_sys);
    instrDone = 1'b0;
  endtask
  task automatic t_cmds;
    ctl(CTL_RST_STOP);
    chkv("reset", 1, 44'(r));
    chkv("halt", 1, 44'(cpuHalt));
    chkv("ctl", 44'h80, 44'(ctlValue));
    u_dbg_host_model.send(CMD_STEP);
    expInstr(1'b1, {1'b1, 3'h0, 40'h0});
    u_dbg_host_model.send(CMD_STUFF);
    u_dbg_host_model.send(8'hE4);
    expInstr(1'b1, {1'b1, 3'h1, 40'hE4});
    u_dbg_host_model.send(CMD_EXEC);
    u_dbg_host_model.send(8'h0C);
    u_dbg_host_model.send(8'h5A);
    expInstr(1'b1, {1'b0, 3'h2, 40'h5A0C});
    c = CRC_INIT;
    for (int i = 0; i < MSZ; i++) begin
      c = c ^ {memByte(ADDR_W'(i)), 8'h00};
      repeat (8) c = c[15] ? (c << 1) ^ CRC_POLY : c << 1;
    end
    u_dbg_host_model.send(CMD_CRC);
    u_dbg_host_model.take(3, g, hi);
    u_dbg_host_model.take(0, g, lo);
    chkv("crc", 44'(c), {28'h0, hi, lo});
    $display("test commands done");
  endtask
  task automatic t_lock;
    lockPin = 1'b1;
    repeat (3) @(negedge clk_sys);
    u_dbg_host_model.send(CMD_STEP);
    expInstr(1'b0, 44'h0);
    u_dbg_host_model.send(CMD_CRC);
    u_dbg_host_model.take(0, g, hi);
    chkv("locked reply", 0, 44'(g));
    // refused execute swallows the next byte even once the lock is gone
    u_dbg_host_model.send(CMD_EXEC);
    lockPin = 1'b0;
    repeat (3) @(negedge clk_sys);
    u_dbg_host_model.send(CMD_EXEC);
    u_dbg_host_model.send(CMD_STEP);
    expInstr(1'b1, {1'b1, 3'h0, 40'h0});
    $display("test lock done");
  endtask
  task automatic t_run;
    ctl(CTL_RUN);
    chkv("run reset", 0, 44'(r));
    chkv("run halt", 0, 44'(cpuHalt));
    u_dbg_host_model.send(CMD_STEP);
    expInstr(1'b0, 44'h0);
    ctl(CTL_RST_GO);
    chkv("go reset", 1, 44'(r));
    chkv("go halt", 0, 44'(cpuHalt));
    $display("test run done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    t_cmds();
    t_lock();
    t_run();
    tally_and_finish();
  end
  // whole run is well under a thousand cycles
  initial begin
    #40000;
    err_total++;
    tally_and_finish();
  end
endmodule
